// >>> vbi_slicer_pkg.sv
// constants shared by the vbi slicer host control logic
package vbi_slicer_pkg;

  // ==========================================================================
  // host port register offsets
  localparam logic [7:0] A_THRESHOLD    = 8'hbd;
  localparam logic [7:0] A_FIFO_OUT_CTL = 8'hc0;
  localparam logic [7:0] A_PIX_ALIGN_LO = 8'hc2;
  localparam logic [7:0] A_PIX_ALIGN_HI = 8'hc3;
  localparam logic [7:0] A_LINE_START   = 8'hd6;
  localparam logic [7:0] A_LINE_STOP    = 8'hd7;
  localparam logic [7:0] A_GLOBAL_MODE  = 8'hd8;
  localparam logic [7:0] A_FF_ENABLE    = 8'hda;
  localparam logic [7:0] A_FF_MODE      = 8'hdb;
  localparam logic [7:0] A_IDATA_FIXED  = 8'he0;
  localparam logic [7:0] A_IDATA_INCR   = 8'he1;
  localparam logic [7:0] A_FIFO_READ    = 8'he2;
  localparam logic [7:0] A_IADDR_LOW    = 8'he8;
  localparam logic [7:0] A_IADDR_MID    = 8'he9;
  localparam logic [7:0] A_IADDR_HIGH   = 8'hea;
  localparam logic [7:0] A_RAW0         = 8'hf0;
  localparam logic [7:0] A_RAW1         = 8'hf1;
  localparam logic [7:0] A_MASKED0      = 8'hf2;
  localparam logic [7:0] A_MASKED1      = 8'hf3;
  localparam logic [7:0] A_MASK0        = 8'hf4;
  localparam logic [7:0] A_MASK1        = 8'hf5;
  localparam logic [7:0] A_CLEAR0       = 8'hf6;
  localparam logic [7:0] A_CLEAR1       = 8'hf7;

  // ==========================================================================
  // reset values and field layout
  localparam logic [9:0] RST_PIX_ALIGN  = 10'h01e;
  localparam logic [7:0] RST_LINE_START = 8'h06;
  localparam logic [7:0] RST_LINE_STOP  = 8'h1b;
  localparam logic [7:0] RST_GLOBAL     = 8'hff;
  localparam logic [7:0] RST_FF_MODE    = 8'hff;
  localparam logic [7:0] RST_THRESHOLD  = 8'h80;
  localparam logic [7:0] MODE_NONE      = 8'hff;
  localparam logic [9:0] PIX_MAX        = 10'h3ff;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  localparam int         FLAGS1_W       = 3;
  localparam int         FULL_BIT       = 0;
  localparam int         ENABLE_BIT     = 0;
  localparam int         ALIGN_HI_W     = 2;

  // ==========================================================================
  // host access sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_IBUS = 3'b010,
    ST_FIFO = 3'b100
  } host_state_e;

endpackage

// >>> vbi_slicer_host_control.sv
// vbi slicer host control: slice mode selection, indirect bus, fifo port, event flags
//
// Contract
// - at the programmed pixel after hsync fall, load the next line's slice mode.
// - switch-point pixel position resets to 0x1e.
// - with full-field disabled, slicing only on lines between line-start and line-stop (resets 06h, 1bh).
// - global slice mode (reset ffh) applies to every line in the region.
// - a per-line mode beats the global mode on its line.
// - full-field enable slices non-blanking lines and per-line ffh lines in full-field mode.
// - full-field mode (reset ffh) has the lowest priority of all.
// - fixed data port moves one byte at the indirect address, address unchanged.
// - incrementing data port moves one byte then advances the address by one.
// - 24-bit indirect address in three byte registers, low byte first.
// - each read of the fifo read port returns the next fifo byte.
// - raw flags 0: threshold, teletext, widescreen, program data, time code, captions, line.
// - raw flags 1: copy-protection change, standard change, fifo full; rest reserved.
// - a line that does not fit sets fifo full and is dropped whole.
// - later lines that fit are still written while fifo full is set.
// - masked flags are raw flags and mask bits ANDed, same layout.
// - interrupt output is the OR of all masked flags.
// - reads never clear flags; only clear registers do.
// - writing one to a clear bit clears the flag; zero has no effect.
// - mask bits reset to zero and enable their source when one.
// - threshold flag sets when fifo word count exceeds threshold (reset 80h).
`timescale 1ns/1ps

module vbi_slicer_host_control #(
  parameter int LEN_W = 11
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [7:0]       host_addr,
  input  wire logic             host_wr,
  input  wire logic             host_rd,
  input  wire logic [7:0]       host_wdata,
  output logic      [7:0]       host_rdata,
  output logic                  host_rvalid,
  output logic                  host_busy,
  input  wire logic             hsync_n,
  input  wire logic             pixel_en,
  input  wire logic [7:0]       line_number,
  input  wire logic             in_vblank,
  input  wire logic [7:0]       per_line_mode,
  output logic      [7:0]       slice_mode,
  output logic                  slice_active,
  output logic                  mode_switch,
  output logic      [23:0]      ibus_addr,
  output logic      [7:0]       ibus_wdata,
  output logic                  ibus_wr,
  output logic                  ibus_rd,
  input  wire logic [7:0]       ibus_rdata,
  input  wire logic             ibus_ack,
  output logic                  fifo_host_en,
  output logic                  fifo_pop,
  input  wire logic [7:0]       fifo_rdata,
  input  wire logic             fifo_rvalid,
  input  wire logic [7:0]       fifo_word_count,
  input  wire logic             line_req,
  input  wire logic [LEN_W-1:0] line_len,
  input  wire logic [LEN_W-1:0] fifo_free,
  output logic                  line_accept,
  output logic                  line_discard,
  input  wire logic [6:0]       evt_data_avail,
  input  wire logic [1:0]       evt_status_chg,
  output logic                  irq
);

  // ==========================================================================
  // state
  localparam int FLAGS1_W_L = vbi_slicer_pkg::FLAGS1_W;
  typedef struct packed {
    logic                          hs_meta;
    logic                          hs_sync;
    logic                          hs_prev;
    logic [9:0]                    pix_cnt;
    logic                          sw_done;
    logic [9:0]                    pix_align;
    logic [7:0]                    line_start;
    logic [7:0]                    line_stop;
    logic [7:0]                    global_mode;
    logic                          ff_en;
    logic [7:0]                    ff_mode;
    logic                          host_acc_en;
    logic [7:0]                    threshold;
    logic [23:0]                   iaddr;
    logic [7:0]                    raw0;
    logic [FLAGS1_W_L-1:0]         raw1;
    logic [7:0]                    mask0;
    logic [FLAGS1_W_L-1:0]         mask1;
    vbi_slicer_pkg::host_state_e   st;
    logic                          acc_incr;
    logic                          acc_read;
    logic [7:0]                    rdata;
    logic                          rvalid;
    logic                          busy;
    logic [7:0]                    ibus_wdata;
    logic                          ibus_wr;
    logic                          ibus_rd;
    logic                          fifo_pop;
    logic [7:0]                    slice_mode;
    logic                          slice_active;
    logic                          mode_switch;
    logic                          line_accept;
    logic                          line_discard;
    logic                          irq;
  } ctl_s;

  ctl_s q;
  ctl_s d;

  // ==========================================================================
  // slice mode selection for the line being entered
  logic                  in_region;
  logic [7:0]            mode_sel;
  logic                  idle;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  fits;
  logic                  thresh_hit;
  logic [7:0]            clr0;
  logic [FLAGS1_W_L-1:0] clr1;
  logic [7:0]            set0;
  logic [FLAGS1_W_L-1:0] set1;
  logic [7:0]            rd_val;

  assign in_region = in_vblank && (line_number >= q.line_start) &&
                     (line_number <= q.line_stop);
  localparam logic [7:0] NONE_L = vbi_slicer_pkg::MODE_NONE; // per-line, then global, then full field
  assign mode_sel = (in_region && per_line_mode != NONE_L) ? per_line_mode :
                    (in_region && q.global_mode != NONE_L) ? q.global_mode :
                    (q.ff_en && (!in_vblank || per_line_mode == NONE_L)) ? q.ff_mode :
                    NONE_L;

  // ==========================================================================
  // host decode; every access is ignored while an indirect or fifo access runs
  assign idle  = (q.st == vbi_slicer_pkg::ST_IDLE);
  assign wr_ok = host_wr && idle;
  assign rd_ok = host_rd && !host_wr && idle;
  assign clr0  = (wr_ok && host_addr == vbi_slicer_pkg::A_CLEAR0) ? host_wdata : 8'h00;
  assign clr1  = (wr_ok && host_addr == vbi_slicer_pkg::A_CLEAR1) ?
                 host_wdata[FLAGS1_W_L-1:0] : '0;

  // ==========================================================================
  // event sources
  assign fits       = (line_len <= fifo_free);
  assign thresh_hit = (fifo_word_count > q.threshold);
  assign set0       = {thresh_hit, evt_data_avail};
  assign set1       = {evt_status_chg, line_req && !fits};

  always_comb begin
    rd_val = vbi_slicer_pkg::READ_ZERO;
    case (host_addr)
      vbi_slicer_pkg::A_THRESHOLD:    rd_val = q.threshold;
      vbi_slicer_pkg::A_FIFO_OUT_CTL: rd_val = {7'h00, q.host_acc_en};
      vbi_slicer_pkg::A_PIX_ALIGN_LO: rd_val = q.pix_align[7:0];
      vbi_slicer_pkg::A_PIX_ALIGN_HI: rd_val = {6'h00, q.pix_align[9:8]};
      vbi_slicer_pkg::A_LINE_START:   rd_val = q.line_start;
      vbi_slicer_pkg::A_LINE_STOP:    rd_val = q.line_stop;
      vbi_slicer_pkg::A_GLOBAL_MODE:  rd_val = q.global_mode;
      vbi_slicer_pkg::A_FF_ENABLE:    rd_val = {7'h00, q.ff_en};
      vbi_slicer_pkg::A_FF_MODE:      rd_val = q.ff_mode;
      vbi_slicer_pkg::A_IADDR_LOW:    rd_val = q.iaddr[7:0];
      vbi_slicer_pkg::A_IADDR_MID:    rd_val = q.iaddr[15:8];
      vbi_slicer_pkg::A_IADDR_HIGH:   rd_val = q.iaddr[23:16];
      vbi_slicer_pkg::A_RAW0:         rd_val = q.raw0;
      vbi_slicer_pkg::A_RAW1:         rd_val = {5'h00, q.raw1};
      vbi_slicer_pkg::A_MASKED0:      rd_val = q.raw0 & q.mask0;
      vbi_slicer_pkg::A_MASKED1:      rd_val = {5'h00, q.raw1 & q.mask1};
      vbi_slicer_pkg::A_MASK0:        rd_val = q.mask0;
      vbi_slicer_pkg::A_MASK1:        rd_val = {5'h00, q.mask1};
      default:                        rd_val = vbi_slicer_pkg::READ_ZERO;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.hs_meta      = hsync_n;
    d.hs_sync      = q.hs_meta;
    d.hs_prev      = q.hs_sync;
    d.rvalid       = 1'b0;
    d.ibus_wr      = 1'b0;
    d.ibus_rd      = 1'b0;
    d.fifo_pop     = 1'b0;
    d.mode_switch  = 1'b0;
    d.line_accept  = 1'b0;
    d.line_discard = 1'b0;

    // pixel counter restarts on the synchronised hsync falling edge
    if (q.hs_prev && !q.hs_sync) begin
      d.pix_cnt = 10'h000;
      d.sw_done = 1'b0;
    end else if (pixel_en) begin
      if (q.pix_cnt == q.pix_align && !q.sw_done) begin
        d.mode_switch  = 1'b1;
        d.sw_done      = 1'b1;
        d.slice_mode   = mode_sel;
        d.slice_active = (mode_sel != vbi_slicer_pkg::MODE_NONE);
      end
      // saturate so a long line cannot wrap into a second switch
      if (q.pix_cnt != vbi_slicer_pkg::PIX_MAX) begin
        d.pix_cnt = q.pix_cnt + 10'h001;
      end
    end

    // line admission: all of a line or none of it
    if (line_req) begin
      d.line_accept  = fits;
      d.line_discard = !fits;
    end

    // host register writes
    if (wr_ok) begin
      case (host_addr)
        vbi_slicer_pkg::A_THRESHOLD:    d.threshold = host_wdata;
        vbi_slicer_pkg::A_FIFO_OUT_CTL: d.host_acc_en = host_wdata[vbi_slicer_pkg::ENABLE_BIT];
        vbi_slicer_pkg::A_PIX_ALIGN_LO: d.pix_align[7:0] = host_wdata;
        vbi_slicer_pkg::A_PIX_ALIGN_HI: d.pix_align[9:8] =
                                          host_wdata[vbi_slicer_pkg::ALIGN_HI_W-1:0];
        vbi_slicer_pkg::A_LINE_START:   d.line_start = host_wdata;
        vbi_slicer_pkg::A_LINE_STOP:    d.line_stop = host_wdata;
        vbi_slicer_pkg::A_GLOBAL_MODE:  d.global_mode = host_wdata;
        vbi_slicer_pkg::A_FF_ENABLE:    d.ff_en = host_wdata[vbi_slicer_pkg::ENABLE_BIT];
        vbi_slicer_pkg::A_FF_MODE:      d.ff_mode = host_wdata;
        vbi_slicer_pkg::A_IADDR_LOW:    d.iaddr[7:0] = host_wdata;
        vbi_slicer_pkg::A_IADDR_MID:    d.iaddr[15:8] = host_wdata;
        vbi_slicer_pkg::A_IADDR_HIGH:   d.iaddr[23:16] = host_wdata;
        vbi_slicer_pkg::A_MASK0:        d.mask0 = host_wdata;
        vbi_slicer_pkg::A_MASK1:        d.mask1 = host_wdata[FLAGS1_W_L-1:0];
        vbi_slicer_pkg::A_IDATA_FIXED,
        vbi_slicer_pkg::A_IDATA_INCR: begin
          d.ibus_wdata = host_wdata;
          d.ibus_wr    = 1'b1;
          d.acc_read   = 1'b0;
          d.acc_incr   = (host_addr == vbi_slicer_pkg::A_IDATA_INCR);
          d.st         = vbi_slicer_pkg::ST_IBUS;
        end
        default: begin
        end
      endcase
    end

    // host reads; status reads have no side effect on the flags
    if (rd_ok) begin
      case (host_addr)
        vbi_slicer_pkg::A_IDATA_FIXED,
        vbi_slicer_pkg::A_IDATA_INCR: begin
          d.ibus_rd  = 1'b1;
          d.acc_read = 1'b1;
          d.acc_incr = (host_addr == vbi_slicer_pkg::A_IDATA_INCR);
          d.st       = vbi_slicer_pkg::ST_IBUS;
        end
        vbi_slicer_pkg::A_FIFO_READ: begin
          // fifo stays with the video output until host access is enabled
          if (q.host_acc_en) begin
            d.fifo_pop = 1'b1;
            d.st       = vbi_slicer_pkg::ST_FIFO;
          end else begin
            d.rdata  = vbi_slicer_pkg::READ_ZERO;
            d.rvalid = 1'b1;
          end
        end
        default: begin
          d.rdata  = rd_val;
          d.rvalid = 1'b1;
        end
      endcase
    end

    // access sequencer
    case (q.st)
      vbi_slicer_pkg::ST_IDLE: begin
      end
      vbi_slicer_pkg::ST_IBUS: begin
        if (ibus_ack) begin
          if (q.acc_read) begin
            d.rdata  = ibus_rdata;
            d.rvalid = 1'b1;
          end
          // address moves only after the transfer so the bus never sees it early
          if (q.acc_incr) begin
            d.iaddr = q.iaddr + 24'h000001;
          end
          d.st = vbi_slicer_pkg::ST_IDLE;
        end
      end
      vbi_slicer_pkg::ST_FIFO: begin
        if (fifo_rvalid) begin
          d.rdata  = fifo_rdata;
          d.rvalid = 1'b1;
          d.st     = vbi_slicer_pkg::ST_IDLE;
        end
      end
      default: d.st = vbi_slicer_pkg::ST_IDLE;
    endcase
    d.busy = (d.st != vbi_slicer_pkg::ST_IDLE);

    // sticky flags; a set in the clearing cycle survives
    d.raw0 = (q.raw0 & ~clr0) | set0;
    d.raw1 = (q.raw1 & ~clr1) | set1;
    d.irq  = (|(d.raw0 & d.mask0)) | (|(d.raw1 & d.mask1));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q             <= '0;
      q.hs_meta     <= 1'b1;
      q.hs_sync     <= 1'b1;
      q.hs_prev     <= 1'b1;
      q.sw_done     <= 1'b1;
      q.pix_align   <= vbi_slicer_pkg::RST_PIX_ALIGN;
      q.line_start  <= vbi_slicer_pkg::RST_LINE_START;
      q.line_stop   <= vbi_slicer_pkg::RST_LINE_STOP;
      q.global_mode <= vbi_slicer_pkg::RST_GLOBAL;
      q.ff_mode     <= vbi_slicer_pkg::RST_FF_MODE;
      q.threshold   <= vbi_slicer_pkg::RST_THRESHOLD;
      q.slice_mode  <= vbi_slicer_pkg::MODE_NONE;
      q.st          <= vbi_slicer_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign host_rdata   = q.rdata;
  assign host_rvalid  = q.rvalid;
  assign host_busy    = q.busy;
  assign slice_mode   = q.slice_mode;
  assign slice_active = q.slice_active;
  assign mode_switch  = q.mode_switch;
  assign ibus_addr    = q.iaddr;
  assign ibus_wdata   = q.ibus_wdata;
  assign ibus_wr      = q.ibus_wr;
  assign ibus_rd      = q.ibus_rd;
  assign fifo_host_en = q.host_acc_en;
  assign fifo_pop     = q.fifo_pop;
  assign line_accept  = q.line_accept;
  assign line_discard = q.line_discard;
  assign irq          = q.irq;

  // ==========================================================================
  // checks
  chk_switch_point: assert property (@(posedge clk) disable iff (rst)
    q.mode_switch |-> ($past(q.pix_cnt) == $past(q.pix_align)))
    else $error("mode switch away from the programmed pixel");

  chk_region_gate: assert property (@(posedge clk) disable iff (rst)
    (q.mode_switch && q.slice_active && !$past(q.ff_en)) |-> $past(in_region))
    else $error("slicing outside the line region");

  chk_per_line_wins: assert property (@(posedge clk) disable iff (rst)
    (q.mode_switch && $past(in_region) && $past(per_line_mode) != vbi_slicer_pkg::MODE_NONE)
    |-> (q.slice_mode == $past(per_line_mode)))
    else $error("per-line mode not taken");

  chk_global_mode: assert property (@(posedge clk) disable iff (rst)
    (q.mode_switch && $past(in_region) && $past(per_line_mode) == NONE_L &&
     $past(q.global_mode) != NONE_L) |-> (q.slice_mode == $past(q.global_mode)))
    else $error("global mode not taken");

  chk_fixed_addr: assert property (@(posedge clk) disable iff (rst)
    (q.st == vbi_slicer_pkg::ST_IBUS && ibus_ack && !q.acc_incr && !wr_ok) |=> $stable(q.iaddr))
    else $error("fixed port moved the address");

  chk_incr_addr: assert property (@(posedge clk) disable iff (rst)
    (q.st == vbi_slicer_pkg::ST_IBUS && ibus_ack && q.acc_incr)
    |=> (q.iaddr == $past(q.iaddr) + 24'h000001))
    else $error("incrementing port did not advance");

  chk_full_drop: assert property (@(posedge clk) disable iff (rst)
    (line_req && !fits) |=> (q.line_discard && !q.line_accept &&
                             q.raw1[vbi_slicer_pkg::FULL_BIT]))
    else $error("oversize line not dropped");

  chk_fit_accept: assert property (@(posedge clk) disable iff (rst)
    (line_req && fits) |=> (q.line_accept && !q.line_discard))
    else $error("fitting line refused");

  chk_irq_or: assert property (@(posedge clk) disable iff (rst)
    q.irq == ((|(q.raw0 & q.mask0)) | (|(q.raw1 & q.mask1))))
    else $error("interrupt differs from masked flags");

  chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (clr0 == 8'h00) |=> ((q.raw0 & $past(q.raw0)) == $past(q.raw0)))
    else $error("flag dropped without a clear");

  chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
    (clr0 != 8'h00) |=> ((q.raw0 & $past(clr0 & ~set0)) == 8'h00))
    else $error("clear write left a flag set");

endmodule

// >>> vbi_far_side_model.sv
// far-side model: internal bus target and vbi fifo source
`timescale 1ns/1ps
module vbi_far_side_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [23:0] ibus_addr,
  input  wire logic [7:0]  ibus_wdata,
  input  wire logic        ibus_wr,
  input  wire logic        ibus_rd,
  output logic      [7:0]  ibus_rdata,
  output logic             ibus_ack,
  input  wire logic        fifo_pop,
  output logic      [7:0]  fifo_rdata,
  output logic             fifo_rvalid
);
  logic [7:0] mem [256];
  logic [7:0] a;
  logic [7:0] nxt;
  initial begin
    mem = '{default: 8'h00};
    ibus_ack = 1'b0;
    fifo_rvalid = 1'b0;
    nxt = 8'h40;
  end
  // ==========================================================================
  // data lines are never left holding the last value between answers
  always @(posedge clk) begin
    if (ibus_wr || ibus_rd) begin
      a = ibus_addr[7:0];
      if (ibus_wr) mem[a] = ibus_wdata;
      repeat (slow ? 3 : 1) @(posedge clk);
      ibus_rdata <= mem[a];
      ibus_ack <= 1'b1;
      @(posedge clk);
      ibus_ack <= 1'b0;
      ibus_rdata <= ~mem[a];
    end
  end
  always @(posedge clk) begin
    if (fifo_pop) begin
      repeat (slow ? 2 : 0) @(posedge clk);
      fifo_rdata <= nxt;
      fifo_rvalid <= 1'b1;
      nxt = nxt + 8'h01;
      @(posedge clk);
      fifo_rvalid <= 1'b0;
      fifo_rdata <= ~nxt;
    end
  end
endmodule

// >>> vbi_slicer_host_control_tb_top.sv
// self-checking testbench of the vbi slicer host control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module vbi_slicer_host_control_tb_top;
  logic        clk, rst, host_wr, host_rd, hsync_n, pixel_en, in_vblank, line_req, slow, idle;
  logic [7:0]  host_addr, host_wdata, host_rdata, line_number, per_line_mode, slice_mode;
  logic        host_rvalid, host_busy, slice_active, mode_switch, ibus_wr, ibus_rd, ibus_ack;
  logic [7:0]  ibus_wdata, ibus_rdata, fifo_rdata, fifo_word_count, raw0, raw1, msk, v, fexp;
  logic        fifo_host_en, fifo_pop, fifo_rvalid, line_accept, line_discard, irq, ffe;
  logic [23:0] ibus_addr, ia;
  logic [10:0] line_len, fifo_free;
  logic [6:0]  evt_data_avail;
  logic [1:0]  evt_status_chg;
  logic [7:0]  mem [256];
  logic [15:0] rt [16] = '{16'hd606, 16'hd71b, 16'hd8ff, 16'hda00, 16'hdbff, 16'hc21e,
    16'hc300, 16'hbd80, 16'hc000, 16'he800, 16'he900, 16'hea00, 16'hf400, 16'hf500,
    16'hf600, 16'h1000};
  int          errors, n_compared;
  vbi_slicer_host_control dut_u (.clk, .rst, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .host_rvalid, .host_busy, .hsync_n, .pixel_en, .line_number, .in_vblank,
    .per_line_mode, .slice_mode, .slice_active, .mode_switch, .ibus_addr, .ibus_wdata,
    .ibus_wr, .ibus_rd, .ibus_rdata, .ibus_ack, .fifo_host_en, .fifo_pop, .fifo_rdata,
    .fifo_rvalid, .fifo_word_count, .line_req, .line_len, .fifo_free, .line_accept,
    .line_discard, .evt_data_avail, .evt_status_chg, .irq);
  vbi_far_side_model far_u (.clk, .slow, .ibus_addr, .ibus_wdata, .ibus_wr, .ibus_rd,
    .ibus_rdata, .ibus_ack, .fifo_pop, .fifo_rdata, .fifo_rvalid);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always_comb idle = !host_busy;
  always @(posedge clk) pixel_en <= 1'($urandom);
  // ==========================================================================
  // host port, event, line admission and video line tasks
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic await(ref logic s);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (s === 1'b1) break;
    end
    if (k == 300) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    await(idle);
  endtask
  task automatic chkrd(input logic [7:0] a, e);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    await(host_rvalid);
    `CHK(host_rdata, e)
  endtask
  task automatic setaddr(input logic [23:0] a);
    wr(8'he8, a[7:0]);
    wr(8'he9, a[15:8]);
    wr(8'hea, a[23:16]);
    `CHK(ibus_addr, a)
  endtask
  task automatic pulse_evt(input logic [6:0] e, input logic [1:0] s);
    @(posedge clk);
    evt_data_avail <= e;
    evt_status_chg <= s;
    @(posedge clk);
    evt_data_avail <= 7'h00;
    evt_status_chg <= 2'h0;
  endtask
  task automatic admit(input int len, free, input logic disc);
    @(posedge clk);
    line_len <= 11'(len);
    fifo_free <= 11'(free);
    line_req <= 1'b1;
    @(posedge clk);
    line_req <= 1'b0;
    @(negedge clk);
    `CHK(line_discard, disc)
    `CHK(line_accept, !disc)
    if (disc) raw1[0] = 1'b1;
  endtask
  task automatic do_line(input logic vb, input logic [7:0] ln, pl);
    logic       inr;
    logic [7:0] e;
    @(posedge clk);
    in_vblank <= vb;
    line_number <= ln;
    per_line_mode <= pl;
    hsync_n <= 1'b0;
    repeat (4) @(posedge clk);
    hsync_n <= 1'b1;
    await(mode_switch);
    inr = vb && ln >= 8'h10 && ln <= 8'h14;
    e = (inr && pl != 8'hff) ? pl : (inr ? 8'h21 : 8'hff);
    if (!inr && ffe && (!vb || pl == 8'hff)) e = 8'h34;
    `CHK(slice_mode, e)
    `CHK(slice_active, e != 8'hff)
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {rst, host_wr, host_rd, in_vblank, line_req, slow} = 6'h21;
    {host_addr, host_wdata, line_number, per_line_mode, fifo_word_count} = 40'h0;
    {hsync_n, pixel_en, line_len, fifo_free, evt_data_avail, evt_status_chg} = 33'h100000000;
    {raw0, raw1, fexp, ffe} = 25'h0000081;
    mem = '{default: 8'h00};
    void'($urandom(32'h7da2));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rt[i]) chkrd(rt[i][15:8], rt[i][7:0]);
    $display("test reset_values done");
    ia = 24'hfffffe;
    setaddr(ia);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      wr(8'he1, v);
      mem[ia[7:0]] = v;
      ia++;
      `CHK(ibus_addr, ia)
    end
    slow = 1'b1;
    ia = 24'hfffffe;
    setaddr(ia);
    for (int i = 0; i < 3; i++) begin
      chkrd(8'he1, mem[ia[7:0]]);
      ia++;
    end
    wr(8'he0, 8'h9c);
    chkrd(8'he0, 8'h9c);
    `CHK(ibus_addr, ia)
    $display("test indirect_bus done");
    chkrd(8'he2, 8'h00);
    wr(8'hc0, 8'h01);
    `CHK(fifo_host_en, 1'b1)
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      chkrd(8'he2, fexp);
      fexp++;
    end
    $display("test fifo_port done");
    for (int i = 0; i < 7; i++) begin
      pulse_evt(7'h01 << i, 2'h0);
      raw0[i] = 1'b1;
      chkrd(8'hf0, raw0);
    end
    fifo_word_count <= 8'h80;
    chkrd(8'hf0, raw0);
    fifo_word_count <= 8'h81;
    raw0[7] = 1'b1;
    chkrd(8'hf0, raw0);
    fifo_word_count <= 8'h00;
    pulse_evt(7'h00, 2'h3);
    raw1 = 8'h06;
    admit(10, 4, 1'b1);
    admit(3, 4, 1'b0);
    chkrd(8'hf1, raw1);
    msk = 8'($urandom);
    wr(8'hf4, msk);
    wr(8'hf5, 8'hff);
    chkrd(8'hf5, 8'h07);
    chkrd(8'hf2, raw0 & msk);
    chkrd(8'hf3, raw1);
    `CHK(irq, 1'b1)
    wr(8'hf7, 8'hff);
    wr(8'hf6, msk);
    raw0 = raw0 & ~msk;
    chkrd(8'hf0, raw0);
    `CHK(irq, 1'b0)
    $display("test event_flags done");
    wr(8'hd6, 8'h10);
    wr(8'hd7, 8'h14);
    wr(8'hd8, 8'h21);
    wr(8'hda, 8'h01);
    wr(8'hdb, 8'h34);
    wr(8'hc2, 8'h0c);
    chkrd(8'hc2, 8'h0c);
    for (int i = 0; i < 10; i++) begin
      do_line(1'($urandom), 8'h0e + 8'($urandom % 9), i[0] ? 8'hff : 8'($urandom % 240));
    end
    wr(8'hda, 8'h00);
    ffe = 1'b0;
    do_line(1'b1, 8'h12, 8'hff);
    do_line(1'b0, 8'h12, 8'h05);
    $display("test slice_mode done");
    complete_run();
  end
endmodule
